/* hdl/pfcp_pkg.sv */
// Types shared by the printer command parser
package pfcp_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ESC, ST_GS, ST_P1, ST_P2, ST_BC_DATA, ST_IMG_DATA
  } pfcp_st_t;
  typedef enum logic [2:0] {
    EK_TEXT, EK_BC_START, EK_BC_CHAR, EK_BC_END, EK_IMG_BYTE,
    EK_IMG_PRINT, EK_DLC_CLEAR
  } pfcp_ek_t;
  typedef struct packed {
    logic valid;
    pfcp_ek_t kind;
    logic [7:0] data;
    logic [7:0] aux;
  } pfcp_eng_t;
  typedef struct packed {
    logic inv;
    logic rot;
    logic [2:0] bw;
    logic [7:0] bh;
    logic [1:0] human_readable_text;
    logic [15:0] pos;
  } pfcp_set_t;
  typedef struct packed {
    pfcp_st_t st;
    logic [8:0] op;
    logic [7:0] p1;
    logic [2:0] bc_type;
    logic bc_on;
    logic [4:0] bc_cnt;
    logic [15:0] bc_dots;
    logic [16:0] img_cnt;
    logic img_def;
    logic [7:0] img_n1;
    logic [5:0] img_n2;
    logic line_start;
    pfcp_set_t set;
    pfcp_eng_t eng;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } pfcp_state_t;
endpackage : pfcp_pkg

/* hdl/pfcp_regs.svh */
// Offsets, field positions, command codes and reset values of the parser
`ifndef PFCP_REGS_SVH
`define PFCP_REGS_SVH
// Register byte offsets
`define PFCP_DATA_OFS 8'h00
`define PFCP_STAT_OFS 8'h04
`define PFCP_POS_OFS 8'h08
`define PFCP_IMG_OFS 8'h0C
`define PFCP_CTRL_OFS 8'h10
// Field positions in the status and control words
`define PFCP_ST_INV 0
`define PFCP_ST_ROT 1
`define PFCP_ST_IMGDEF 16
`define PFCP_ST_LSTART 17
`define PFCP_ST_BCACT 18
`define PFCP_CTRL_LSTART 0
// Stream control bytes
`define PFCP_ESC 8'h1B
`define PFCP_GS 8'h1D
`define PFCP_LF 8'h0A
`define PFCP_NUL 8'h00
// Opcodes: bit 8 set means a group separator command
`define PFCP_OP_INV 9'h07B
`define PFCP_OP_ROT 9'h056
`define PFCP_OP_ABS 9'h024
`define PFCP_OP_REL 9'h05C
`define PFCP_OP_INIT 9'h040
`define PFCP_OP_DEL 9'h026
`define PFCP_OP_BC 9'h16B
`define PFCP_OP_BCW 9'h177
`define PFCP_OP_BCH 9'h168
`define PFCP_OP_HRI 9'h148
`define PFCP_OP_IMGDEF 9'h12A
`define PFCP_OP_IMGPR 9'h12F
// Reset values and limits
`define PFCP_BCW_RST 3'h3
`define PFCP_BCH_RST 8'hA2
`define PFCP_HRI_RST 2'h0
`define PFCP_IMG_N2_MAX 8'h30
`define PFCP_LINE_DOTS 16'h0240
`define PFCP_LINE_BYTES 8'h48
`define PFCP_BC_MODULES 8'h0B
`endif

/* hdl/pfcp_top.sv */
// Printer command stream parser with APB register access
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`include "pfcp_regs.svh"
// Overview of operation
// - Inverted mode follows bit zero, resets off
// - Inverted change applies only at line start
// - Rotate command 1 enables, 0 cancels
// - Absolute position is low plus high times 256
// - Absolute position past line end is discarded
// - Relative position is signed 16-bit dot offset
// - Relative move past line end is discarded
// - Bar code type selects symbology, data printed
// - Types 4-7 limited to 15/26/19/17 characters
// - Bar code ignored while print data pending
// - Unprintable bar code byte ends code, prints text
// - After bar code, start of line; clip overflow
// - Bar code width 2 to 4, default 3
// - Bar height 1 to 255 dots, default 162
// - Readable text none/above/below/both, default none
// - Image is n1x8 by n2x8 dots, n2 at most 48
// - Image kept until redefined, initialize or delete
// - Defining an image clears download characters
// - Image print modes 0 to 3 set densities
// - Image print ignored if data pending or undefined
module pfcp_top (
  input wire logic SYS_CLK_IN,
  input wire logic RESET_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic [31:0] PRDATA_OUT,
  output pfcp_pkg::pfcp_eng_t ENG_OUT,
  output pfcp_pkg::pfcp_set_t SETTINGS_OUT
);
  import pfcp_pkg::*;

  pfcp_state_t q;
  pfcp_state_t d;
  logic [7:0] b;
  logic wr_byte;
  logic wr_ctrl;

  // Parameter bytes each opcode needs
  function automatic logic [1:0] npar(input logic [8:0] op);
    unique case (op)
      `PFCP_OP_ABS, `PFCP_OP_REL, `PFCP_OP_IMGDEF: npar = 2'd2;
      `PFCP_OP_INIT, `PFCP_OP_DEL: npar = 2'd0;
      `PFCP_OP_INV, `PFCP_OP_ROT, `PFCP_OP_BC, `PFCP_OP_BCW,
      `PFCP_OP_BCH, `PFCP_OP_HRI, `PFCP_OP_IMGPR: npar = 2'd1;
      default: npar = 2'd0;
    endcase
  endfunction : npar

  // Column limit per symbology; zero means no printer limit
  function automatic logic [4:0] bc_max(input logic [2:0] t);
    unique case (t)
      3'd4: bc_max = 5'd15;
      3'd5: bc_max = 5'd26;
      3'd6: bc_max = 5'd19;
      3'd7: bc_max = 5'd17;
      default: bc_max = 5'd0;
    endcase
  endfunction : bc_max

  // Whether a byte can be encoded in the symbology
  function automatic logic bc_ok(input logic [2:0] t, input logic [7:0] c);
    logic dig;
    dig = (c >= 8'h30) && (c <= 8'h39);
    unique case (t)
      3'd4: bc_ok = dig || (c >= 8'h41 && c <= 8'h5A) || c == 8'h20 ||
                    c == 8'h24 || c == 8'h25 || c == 8'h2B ||
                    (c >= 8'h2D && c <= 8'h2F);
      3'd6: bc_ok = dig || (c >= 8'h41 && c <= 8'h44) || c == 8'h24 ||
                    c == 8'h2B || c == 8'h2D || c == 8'h2E ||
                    c == 8'h2F || c == 8'h3A;
      3'd7: bc_ok = c <= 8'h7F;
      default: bc_ok = dig;
    endcase
  endfunction : bc_ok

  // A transfer completes on the edge where the registered ready is seen
  assign b = PWDATA_IN[7:0];
  assign wr_byte = PSEL_IN && PENABLE_IN && q.pready && PWRITE_IN &&
                   PADDR_IN == `PFCP_DATA_OFS;
  assign wr_ctrl = PSEL_IN && PENABLE_IN && q.pready && PWRITE_IN &&
                   PADDR_IN == `PFCP_CTRL_OFS;

  // Next state: bus answer, then one stream byte per write
  always_comb begin
    logic [15:0] v;
    logic [16:0] rel;
    logic [15:0] step;
    logic [7:0] lim;
    v = {b, q.p1};
    rel = 17'(q.set.pos) + {v[15], v};
    step = 16'(`PFCP_BC_MODULES * q.set.bw);
    lim = b[0] ? (`PFCP_LINE_BYTES >> 1) : `PFCP_LINE_BYTES;
    d = q;
    d.eng.valid = 1'b0;
    // One wait state keeps read data and ready both registered
    d.pready = PSEL_IN && PENABLE_IN && !q.pready;
    d.pslverr = 1'b0;
    if (PSEL_IN && !q.pready) begin
      d.prdata = 32'h0;
      unique case (PADDR_IN)
        `PFCP_DATA_OFS: d.prdata = 32'h0;
        `PFCP_STAT_OFS: begin
          d.prdata[`PFCP_ST_INV] = q.set.inv;
          d.prdata[`PFCP_ST_ROT] = q.set.rot;
          d.prdata[3:2] = q.set.human_readable_text;
          d.prdata[6:4] = q.set.bw;
          d.prdata[15:8] = q.set.bh;
          d.prdata[`PFCP_ST_IMGDEF] = q.img_def;
          d.prdata[`PFCP_ST_LSTART] = q.line_start;
          d.prdata[`PFCP_ST_BCACT] = q.st == ST_BC_DATA;
        end
        `PFCP_POS_OFS: d.prdata[15:0] = q.set.pos;
        `PFCP_IMG_OFS: d.prdata[13:0] = {q.img_n2, q.img_n1};
        `PFCP_CTRL_OFS: d.prdata[`PFCP_CTRL_LSTART] = q.line_start;
        default: d.pslverr = PENABLE_IN;
      endcase
    end
    // Engine reports the line printed and the buffer empty
    if (wr_ctrl && PWDATA_IN[`PFCP_CTRL_LSTART]) begin
      d.line_start = 1'b1;
      d.set.pos = 16'h0;
    end
    if (wr_byte) begin
      unique case (q.st)
        ST_IDLE: begin
          if (b == `PFCP_ESC) begin
            d.st = ST_ESC;
          end else if (b == `PFCP_GS) begin
            d.st = ST_GS;
          end else begin
            d.eng = '{1'b1, EK_TEXT, b, 8'h0};
            d.line_start = b == `PFCP_LF;
          end
        end
        ST_ESC, ST_GS: begin
          d.op = {q.st == ST_GS, b};
          d.st = ST_IDLE;
          if (npar({q.st == ST_GS, b}) != 2'd0) begin
            d.st = ST_P1;
          end else if ({q.st == ST_GS, b} == `PFCP_OP_INIT) begin
            d.set = '{1'b0, 1'b0, `PFCP_BCW_RST, `PFCP_BCH_RST,
                      `PFCP_HRI_RST, 16'h0};
            d.img_def = 1'b0;
            d.line_start = 1'b1;
          end else if ({q.st == ST_GS, b} == `PFCP_OP_DEL) begin
            d.img_def = 1'b0;
          end
        end
        ST_P1: begin
          d.p1 = b;
          d.st = npar(q.op) == 2'd2 ? ST_P2 : ST_IDLE;
          unique case (q.op)
            `PFCP_OP_INV: begin
              if (q.line_start) begin
                d.set.inv = b[0];
              end
            end
            `PFCP_OP_ROT: begin
              if (b <= 8'h01) begin
                d.set.rot = b[0];
              end
            end
            `PFCP_OP_BCW: begin
              if (b >= 8'h02 && b <= 8'h04) begin
                d.set.bw = b[2:0];
              end
            end
            `PFCP_OP_BCH: begin
              if (b != 8'h00) begin
                d.set.bh = b;
              end
            end
            `PFCP_OP_HRI: begin
              if (b <= 8'h03) begin
                d.set.human_readable_text = b[1:0];
              end
            end
            `PFCP_OP_BC: begin
              if (b <= 8'h07) begin
                d.st = ST_BC_DATA;
                d.bc_type = b[2:0];
                d.bc_cnt = 5'd0;
                d.bc_dots = 16'h0;
                d.bc_on = q.line_start;
                if (q.line_start) begin
                  d.eng = '{1'b1, EK_BC_START, b,
                            {q.set.human_readable_text, q.set.bw, 3'h0}};
                end
              end
            end
            `PFCP_OP_IMGPR: begin
              // Clip width to what fits in one line
              if (b <= 8'h03 && q.img_def && q.line_start) begin
                d.eng = '{1'b1, EK_IMG_PRINT, b,
                          q.img_n1 < lim ? q.img_n1 : lim};
              end
            end
            // Two-byte commands keep the second parameter state
            default: ;
          endcase
        end
        ST_P2: begin
          d.st = ST_IDLE;
          unique case (q.op)
            `PFCP_OP_ABS: begin
              if (v < `PFCP_LINE_DOTS) begin
                d.set.pos = v;
              end
            end
            `PFCP_OP_REL: begin
              // Leftward past the start is dropped the same way
              if (!rel[16] && rel[15:0] < `PFCP_LINE_DOTS) begin
                d.set.pos = rel[15:0];
              end
            end
            `PFCP_OP_IMGDEF: begin
              if (q.p1 != 8'h00 && b != 8'h00 &&
                  b <= `PFCP_IMG_N2_MAX) begin
                d.img_n1 = q.p1;
                d.img_n2 = b[5:0];
                d.img_def = 1'b0;
                d.img_cnt = 17'({q.p1, 3'b000}) * 17'(b[5:0]);
                d.st = ST_IMG_DATA;
                d.eng = '{1'b1, EK_DLC_CLEAR, 8'h0, 8'h0};
              end
            end
            default: d.st = ST_IDLE;
          endcase
        end
        ST_BC_DATA: begin
          if (b == `PFCP_NUL || !bc_ok(q.bc_type, b)) begin
            d.st = ST_IDLE;
            if (q.bc_on) begin
              d.set.pos = 16'h0;
              d.line_start = 1'b1;
            end
            if (b != `PFCP_NUL) begin
              // Offending byte goes out as text; later bytes are parsed from idle
              d.eng = '{1'b1, q.bc_on ? EK_BC_END : EK_TEXT, b,
                        {7'h0, q.bc_on}};
              d.line_start = 1'b0;
            end else if (q.bc_on) begin
              d.eng = '{1'b1, EK_BC_END, b, 8'h0};
            end
          end else if (q.bc_on &&
                       (bc_max(q.bc_type) == 5'd0 ||
                        q.bc_cnt < bc_max(q.bc_type)) &&
                       q.bc_dots + step <= `PFCP_LINE_DOTS) begin
            d.bc_cnt = q.bc_cnt + 5'd1;
            d.bc_dots = q.bc_dots + step;
            d.eng = '{1'b1, EK_BC_CHAR, b, {5'h0, q.bc_type}};
          end
        end
        ST_IMG_DATA: begin
          d.img_cnt = q.img_cnt - 17'd1;
          d.eng = '{1'b1, EK_IMG_BYTE, b, 8'h0};
          if (q.img_cnt == 17'd1) begin
            d.st = ST_IDLE;
            d.img_def = 1'b1;
          end
        end
        default: d.st = ST_IDLE;
      endcase
    end
  end

  // Single state register; reset loads the power-up settings
  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      q <= '0;
      q.st <= ST_IDLE;
      q.line_start <= 1'b1;
      q.set.bw <= `PFCP_BCW_RST;
      q.set.bh <= `PFCP_BCH_RST;
      q.set.human_readable_text <= `PFCP_HRI_RST;
    end else begin
      q <= d;
    end
  end

  assign PREADY_OUT = q.pready;
  assign PSLVERR_OUT = q.pslverr;
  assign PRDATA_OUT = q.prdata;
  assign ENG_OUT = q.eng;
  assign SETTINGS_OUT = q.set;

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  sequence s_bc_open;
    wr_byte && q.st == ST_P1 && q.op == `PFCP_OP_BC && b <= 8'h07
    ##1 q.st == ST_BC_DATA;
  endsequence

  a_inv_bit_zero: assert property (
    wr_byte && q.st == ST_P1 && q.op == `PFCP_OP_INV && q.line_start
    |=> q.set.inv == $past(PWDATA_IN[0]))
    else $error("inverted mode not taken from bit zero");
  a_inv_midline: assert property (
    wr_byte && q.st == ST_P1 && q.op == `PFCP_OP_INV && !q.line_start
    |=> $stable(q.set.inv))
    else $error("inverted mode changed mid line");
  a_rot_apply: assert property (
    wr_byte && q.st == ST_P1 && q.op == `PFCP_OP_ROT && b <= 8'h01
    |=> q.set.rot == $past(PWDATA_IN[0]))
    else $error("rotation setting wrong");
  a_abs_set: assert property (
    wr_byte && q.st == ST_P2 && q.op == `PFCP_OP_ABS &&
    {b, q.p1} < `PFCP_LINE_DOTS
    |=> q.set.pos == $past({PWDATA_IN[7:0], q.p1}))
    else $error("absolute position wrong");
  a_abs_drop: assert property (
    wr_byte && q.st == ST_P2 && q.op == `PFCP_OP_ABS &&
    {b, q.p1} >= `PFCP_LINE_DOTS |=> $stable(q.set.pos))
    else $error("out of line position taken");
  a_bc_limit: assert property (
    wr_byte && q.st == ST_BC_DATA && bc_ok(q.bc_type, b) && b != 8'h00 &&
    bc_max(q.bc_type) != 5'd0 && q.bc_cnt >= bc_max(q.bc_type)
    |=> !q.eng.valid)
    else $error("bar code column limit passed");
  a_bc_pending: assert property (
    s_bc_open ##0 !q.bc_on |-> !(q.eng.valid && q.eng.kind == EK_BC_START))
    else $error("bar code started with data pending");
  a_bc_home: assert property (
    s_bc_open ##0 q.bc_on ##[0:300] (wr_byte && b == 8'h00 &&
    q.st == ST_BC_DATA) |=> q.set.pos == 16'h0 && q.st == ST_IDLE)
    else $error("bar code did not return to line start");
  a_bcw_range: assert property (
    q.set.bw >= 3'd2 && q.set.bw <= 3'd4)
    else $error("bar code width out of range");
  a_img_clear: assert property (
    wr_byte && q.st == ST_P2 && q.op == `PFCP_OP_IMGDEF && q.p1 != 8'h0 &&
    b != 8'h0 && b <= `PFCP_IMG_N2_MAX
    |=> q.eng.valid && q.eng.kind == EK_DLC_CLEAR && !q.img_def)
    else $error("download characters not cleared");
  a_img_ignore: assert property (
    wr_byte && q.st == ST_P1 && q.op == `PFCP_OP_IMGPR &&
    (!q.img_def || !q.line_start) |=> !q.eng.valid)
    else $error("image printed when it must be ignored");
  a_img_clip: assert property (
    q.eng.valid && q.eng.kind == EK_IMG_PRINT
    |-> q.eng.aux <= (q.eng.data[0] ? 8'h24 : 8'h48))
    else $error("image wider than line");
  a_ready_pulse: assert property (
    PREADY_OUT |=> !PREADY_OUT)
    else $error("ready held for more than one cycle");
  a_rel_drop: assert property (
    wr_byte && q.st == ST_P2 && q.op == `PFCP_OP_REL &&
    17'(q.set.pos) + {b[7], b, q.p1} >= 17'(`PFCP_LINE_DOTS)
    |=> $stable(q.set.pos))
    else $error("relative move past line end taken");
  a_bch_zero: assert property (
    wr_byte && q.st == ST_P1 && q.op == `PFCP_OP_BCH && b == 8'h00
    |=> $stable(q.set.bh))
    else $error("zero bar height taken");
  a_hri_range: assert property (
    wr_byte && q.st == ST_P1 && q.op == `PFCP_OP_HRI && b > 8'h03
    |=> $stable(q.set.human_readable_text))
    else $error("readable text position out of range taken");
  a_img_n2_limit: assert property (
    wr_byte && q.st == ST_P2 && q.op == `PFCP_OP_IMGDEF &&
    b > `PFCP_IMG_N2_MAX |=> q.st == ST_IDLE)
    else $error("image taller than limit accepted");

endmodule : pfcp_top

/* testbench/pfcp_engine_model.sv */
// Print engine stand-in that records the events the parser sends
`timescale 1ns/1ps
module pfcp_engine_model
  import pfcp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire pfcp_pkg::pfcp_eng_t eng_in,
  output logic [7:0] ev_count_out,
  output logic [7:0] bc_chars_out,
  output pfcp_pkg::pfcp_eng_t last_out
);
  // Engine cannot stall, so every valid pulse is taken on its own edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ev_count_out <= 8'h00;
      bc_chars_out <= 8'h00;
      last_out <= '0;
    end else if (eng_in.valid === 1'b1) begin
      ev_count_out <= ev_count_out + 8'h01;
      last_out <= eng_in;
      if (eng_in.kind == EK_BC_CHAR) begin
        bc_chars_out <= bc_chars_out + 8'h01;
      end
    end
  end
endmodule : pfcp_engine_model

/* testbench/test_pfcp_top.sv */
// Self-checking bench for the printer command parser
`timescale 1ns/1ps
module test_pfcp_top;
  import pfcp_pkg::*;
  localparam logic [7:0] E = 8'h1B;
  localparam logic [7:0] G = 8'h1D;
  logic clk, rst_n, psel, pen, pwr, rdy, err, err_q;
  logic [7:0] paddr, evc, bcc, base;
  logic [31:0] pwdata, prdata, r;
  pfcp_eng_t eng, last;
  pfcp_set_t st;
  int fail_count, comparisons, cycles;
  pfcp_top pfcp_top_inst (.SYS_CLK_IN(clk), .RESET_N_IN(rst_n),
    .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PREADY_OUT(rdy), .PSLVERR_OUT(err),
    .PRDATA_OUT(prdata), .ENG_OUT(eng), .SETTINGS_OUT(st));
  pfcp_engine_model pfcp_engine_model_inst (.clk_in(clk), .rst_n_in(rst_n),
    .eng_in(eng), .ev_count_out(evc), .bc_chars_out(bcc), .last_out(last));
  // 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task give_verdict;
    $display("fails %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR t=%0t got %h expected %h", $time, g, x);
    end
  endtask : chk
  // One APB transfer; pready sampled before the edge's own updates land
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prdata;
    er = err;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task rd_chk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, r, err_q);
    chk(r, x);
  endtask : rd_chk
  // Byte stream into the data register, then let events settle
  task send(input logic [7:0] b[$]);
    foreach (b[i]) apb(1'b1, 8'h00, {24'h0, b[i]}, r, err_q);
    repeat (2) @(negedge clk);
  endtask : send
  task line_done;
    apb(1'b1, 8'h10, 32'h1, r, err_q);
    repeat (2) @(negedge clk);
  endtask : line_done
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(8'h04, 32'h0002A230);
    apb(1'b0, 8'h20, 32'h0, r, err_q);
    chk({31'h0, err_q}, 32'h1);
    // Only bit zero counts
    send('{E, 8'h7B, 8'h03});
    chk({31'h0, st.inv}, 32'h1);
    send('{E, 8'h7B, 8'h02});
    chk({31'h0, st.inv}, 32'h0);
    send('{E, 8'h56, 8'h01});
    chk({31'h0, st.rot}, 32'h1);
    send('{E, 8'h24, 8'h3F, 8'h02});
    chk({16'h0, st.pos}, 32'h023F);
    rd_chk(8'h08, 32'h0000023F);
    send('{E, 8'h24, 8'h40, 8'h02});
    chk({16'h0, st.pos}, 32'h023F);
    send('{E, 8'h5C, 8'hFF, 8'hFF});
    chk({16'h0, st.pos}, 32'h023E);
    send('{E, 8'h5C, 8'h02, 8'h00});
    chk({16'h0, st.pos}, 32'h023E);
    // Mid-line inversion change must not land
    base = evc;
    send('{8'h41, E, 8'h7B, 8'h01});
    chk({31'h0, st.inv}, 32'h0);
    chk({24'h0, evc - base}, 32'h1);
    // Pending text blocks a bar code, its bytes swallowed
    send('{G, 8'h6B, 8'h04, 8'h41, 8'h00});
    chk({24'h0, evc - base}, 32'h1);
    line_done();
    send('{E, 8'h24, 8'h10, 8'h00});
    base = evc;
    send('{G, 8'h6B, 8'h04, 8'h41, 8'h00});
    chk({24'h0, evc - base}, 32'h3);
    chk({29'h0, last.kind}, {29'h0, EK_BC_END});
    chk({16'h0, st.pos}, 32'h0);
    base = bcc;
    send('{G, 8'h6B, 8'h04});
    for (int i = 0; i < 16; i++) send('{8'h41});
    send('{8'h00});
    chk({24'h0, bcc - base}, 32'd15);
    // Fixed-length code with exactly its eleven digits
    base = bcc;
    send('{G, 8'h6B, 8'h00, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35,
           8'h36, 8'h37, 8'h38, 8'h39, 8'h30, 8'h00});
    chk({24'h0, bcc - base}, 32'd11);
    // Unprintable byte ends the code and goes out as text
    send('{G, 8'h6B, 8'h04, 8'h41, 8'h01});
    chk({29'h0, last.kind}, {29'h0, EK_BC_END});
    chk({24'h0, last.data}, 32'h1);
    chk({31'h0, last.aux[0]}, 32'h1);
    line_done();
    send('{G, 8'h77, 8'h04, G, 8'h77, 8'h05});
    chk({29'h0, st.bw}, 32'h4);
    send('{G, 8'h68, 8'h01, G, 8'h68, 8'h00});
    chk({24'h0, st.bh}, 32'h1);
    send('{G, 8'h48, 8'h03, G, 8'h48, 8'h04});
    chk({30'h0, st.human_readable_text}, 32'h3);
    base = evc;
    send('{G, 8'h2F, 8'h00});
    chk({24'h0, evc - base}, 32'h0);
    send('{G, 8'h2A, 8'h01, 8'h31, G, 8'h2A, 8'h01, 8'h01});
    for (int i = 0; i < 8; i++) send('{8'hA5});
    chk({24'h0, evc - base}, 32'h9);
    rd_chk(8'h0C, 32'h0101);
    apb(1'b0, 8'h04, 32'h0, r, err_q);
    chk({31'h0, r[16]}, 32'h1);
    send('{G, 8'h2F, 8'h03});
    chk({29'h0, last.kind}, {29'h0, EK_IMG_PRINT});
    chk({24'h0, last.data}, 32'h3);
    send('{E, 8'h26});
    apb(1'b0, 8'h04, 32'h0, r, err_q);
    chk({31'h0, r[16]}, 32'h0);
    give_verdict();
  end
endmodule : test_pfcp_top
